// ### rtl/sfcp_map.svh
// Constants of the serial flash command port: opcodes, fields, timing.
//
// Function
// - Accept select fall with clock low or high.
// - Sample serial input on rising clock edges.
// - Clock idle low: mode 0; high: mode 3.
// - Every item is one byte of eight clocks.
// - Decode page read, buffer one and two read.
// - Decode page to buffer transfer, self-timed.
// - Decode page to buffer compare, self-timed.
// - Decode buffer writes from given byte address.
// - Page number sits above ten buffer bits.
// - Reserved top address bits are dropped from the page number.
// - Status read takes no address bytes.
// - Mode latched at select fall; reset mode 3.
// - Buffer commands use low ten address bits.
// - Busy pin low during self-timed work.
`ifndef SFCP_MAP_SVH
`define SFCP_MAP_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFCP_OP_PAGE_RD 8'h52
`define SFCP_OP_BUF1_RD 8'h54
`define SFCP_OP_BUF2_RD 8'h56
`define SFCP_OP_XFER1 8'h53
`define SFCP_OP_XFER2 8'h55
`define SFCP_OP_CMP1 8'h60
`define SFCP_OP_CMP2 8'h61
`define SFCP_OP_BUF1_WR 8'h84
`define SFCP_OP_BUF2_WR 8'h87
`define SFCP_OP_STATUS 8'h57

// ----------------------------------------------------------------------
// Address layout and framing
// ----------------------------------------------------------------------
`define SFCP_PAGE_MSB 21
`define SFCP_PAGE_LSB 10
`define SFCP_BYTE_MSB 9
`define SFCP_BUF_BYTES 10'h210
`define SFCP_BUF_LAST 10'h20f
`define SFCP_ADDR_LAST 3'h2
`define SFCP_PAGE_RD_DUMMY 3'h4
`define SFCP_BUF_RD_DUMMY 3'h1
`define SFCP_STAT_FIXED 3'h5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFCP_CLK_MHZ 20
`define SFCP_T_XFR_US 350
`define SFCP_XFR_CYCLES (`SFCP_T_XFR_US * `SFCP_CLK_MHZ)

`endif

// ### rtl/sfcp_pkg.sv
// Types of the serial flash command port.
package sfcp_pkg;

    // Serial pins as seen from the host.
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sfcp_pin_t;

    // Byte request towards the main memory array.
    typedef struct packed {
        logic [11:0] page;
        logic [9:0] byte_idx;
    } sfcp_core_req_t;

    typedef enum logic [2:0] {
        ph_idle, ph_cmd, ph_addr, ph_dummy,
        ph_read, ph_write, ph_armed, ph_ignore
    } sfcp_phase_t;

    // Whole state of the command port.
    typedef struct packed {
        sfcp_pin_t s1;
        sfcp_pin_t s2;
        sfcp_pin_t s3;
        sfcp_pin_t pins;
        sfcp_phase_t ph;
        logic [7:0] opcode;
        logic [7:0] shin;
        logic [2:0] bitc;
        logic [2:0] bytec;
        logic [2:0] ndum;
        logic [23:0] addr;
        logic [7:0] sh_out;
        logic so;
        logic oe_n;
        logic mode3;
        logic busy;
        logic busy_buf;
        logic op_cmp;
        logic mismatch;
        logic [15:0] timer;
        logic [11:0] op_page;
        logic [9:0] walk;
    } sfcp_state_t;

endpackage

// ### rtl/sfcp_port.sv
// Serial command port with two byte buffers and self-timed array work.
`timescale 1ns/100ps
`default_nettype none
`include "sfcp_map.svh"

module sfcp_port import sfcp_pkg::*; #(
    parameter int XFR_CYCLES = `SFCP_XFR_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Serial link.
    input wire sfcp_pin_t spi_in,
    output logic so,
    output logic so_oe_n,
    // Open-drain ready/busy pin.
    output logic rdy_busy_o,
    output logic rdy_busy_oe_n,
    // Main memory array read port.
    output sfcp_core_req_t core_req,
    input wire logic [7:0] core_rdata,
    // Status.
    output logic spi_mode3
);

    // ------------------------------------------------------------------
    // State and buffers
    // ------------------------------------------------------------------
    sfcp_state_t st_reg;
    sfcp_state_t st_next;
    logic [7:0] buf_mem [0:1055];
    logic cs_fall, cs_rise, rise, fall, do_load, hsel, hbusy;
    logic [7:0] in_byte, stat, rd_a, rd_b;
    logic [23:0] full_addr;
    logic wa_en, wb_en;
    logic [10:0] wa_idx, wb_idx;
    logic [7:0] wa_data, wb_data;

    // Buffer index: buffer two sits above buffer one.
    function automatic logic [10:0] bidx(input logic sel, input logic [9:0] p);
        bidx = (sel ? {1'b0, `SFCP_BUF_BYTES} : 11'h000) + {1'b0, p};
    endfunction

    // Pointer step inside one buffer or page, wrapping at its end.
    function automatic logic [9:0] step(input logic [9:0] p);
        step = (p == `SFCP_BUF_LAST) ? 10'h000 : p + 10'h001;
    endfunction

    // Opcodes that are followed by three address bytes.
    function automatic logic addr_cmd(input logic [7:0] op);
        case (op)
            `SFCP_OP_PAGE_RD, `SFCP_OP_BUF1_RD, `SFCP_OP_BUF2_RD,
            `SFCP_OP_XFER1, `SFCP_OP_XFER2, `SFCP_OP_CMP1,
            `SFCP_OP_CMP2, `SFCP_OP_BUF1_WR, `SFCP_OP_BUF2_WR:
                addr_cmd = 1'b1;
            default:
                addr_cmd = 1'b0;
        endcase
    endfunction

    // Asynchronous reads of the host side and the self-timed side.
    assign rd_a = buf_mem[bidx(hsel, st_reg.addr[`SFCP_BYTE_MSB:0])];
    assign rd_b = buf_mem[bidx(st_reg.busy_buf, st_reg.walk)];

    // Host buffer select and its clash with the busy buffer.
    assign hsel = (st_reg.opcode == `SFCP_OP_BUF2_RD) ||
                  (st_reg.opcode == `SFCP_OP_BUF2_WR);
    assign hbusy = st_reg.busy && (st_reg.busy_buf == hsel);

    // Live status byte; low three bits read zero.
    assign stat = {!st_reg.busy, st_reg.mismatch,
                   `SFCP_STAT_FIXED, 3'h0};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Pins pass three flops; a level counts once stages two and three
    // agree, which rejects a single glitch sample at the cost of delay.
    always_comb begin
        st_next = st_reg;
        wa_en = 1'b0;
        wa_idx = 11'h000;
        wa_data = 8'h00;
        wb_en = 1'b0;
        wb_idx = 11'h000;
        wb_data = 8'h00;
        do_load = 1'b0;
        st_next.s1 = spi_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2.cs_n == st_reg.s3.cs_n) begin
            st_next.pins.cs_n = st_reg.s3.cs_n;
        end
        if (st_reg.s2.sck == st_reg.s3.sck) begin
            st_next.pins.sck = st_reg.s3.sck;
        end
        if (st_reg.s2.si == st_reg.s3.si) begin
            st_next.pins.si = st_reg.s3.si;
        end
        cs_fall = st_reg.pins.cs_n && !st_next.pins.cs_n;
        cs_rise = !st_reg.pins.cs_n && st_next.pins.cs_n;
        rise = !st_reg.pins.sck && st_next.pins.sck &&
               !st_next.pins.cs_n;
        fall = st_reg.pins.sck && !st_next.pins.sck &&
               !st_next.pins.cs_n;
        in_byte = {st_reg.shin[6:0], st_next.pins.si};
        full_addr = {st_reg.addr[15:0], in_byte};

        if (cs_fall) begin
            // Either idle clock level starts a command.
            st_next.ph = ph_cmd;
            st_next.bitc = 3'h0;
            st_next.mode3 = st_next.pins.sck;
        end else if (cs_rise) begin
            // Raising select ends the command and launches array work if a transfer or compare is armed and not busy.
            if (st_reg.ph == ph_armed && !st_reg.busy) begin
                st_next.busy = 1'b1;
                st_next.timer = 16'(XFR_CYCLES);
                st_next.walk = 10'h000;
                st_next.op_page =
                    st_reg.addr[`SFCP_PAGE_MSB:`SFCP_PAGE_LSB];
                st_next.busy_buf =
                    (st_reg.opcode == `SFCP_OP_XFER2) ||
                    (st_reg.opcode == `SFCP_OP_CMP2);
                st_next.op_cmp =
                    (st_reg.opcode == `SFCP_OP_CMP1) ||
                    (st_reg.opcode == `SFCP_OP_CMP2);
                if (st_next.op_cmp) begin
                    st_next.mismatch = 1'b0;
                end
            end
            st_next.ph = ph_idle;
            st_next.oe_n = 1'b1;
        end else if (rise) begin
            st_next.shin = in_byte;
            st_next.bitc = st_reg.bitc + 3'h1;
            if (st_reg.bitc == 3'h7) begin
                case (st_reg.ph)
                    ph_cmd: begin
                        st_next.opcode = in_byte;
                        st_next.bytec = 3'h0;
                        if (in_byte == `SFCP_OP_STATUS) begin
                            st_next.ph = ph_read;
                            st_next.sh_out = stat;
                        end else if (addr_cmd(in_byte)) begin
                            st_next.ph = ph_addr;
                        end else begin
                            st_next.ph = ph_ignore;
                        end
                    end
                    ph_addr: begin
                        st_next.addr = full_addr;
                        st_next.bytec = st_reg.bytec + 3'h1;
                        if (st_reg.bytec == `SFCP_ADDR_LAST) begin
                            st_next.bytec = 3'h0;
                            case (st_reg.opcode)
                                `SFCP_OP_PAGE_RD: begin
                                    // Reserved top bits are dropped.
                                    st_next.op_page = full_addr[
                                        `SFCP_PAGE_MSB:`SFCP_PAGE_LSB];
                                    st_next.walk =
                                        full_addr[`SFCP_BYTE_MSB:0];
                                    st_next.ndum = `SFCP_PAGE_RD_DUMMY;
                                    st_next.ph = st_reg.busy ?
                                        ph_ignore : ph_dummy;
                                end
                                `SFCP_OP_BUF1_RD,
                                `SFCP_OP_BUF2_RD: begin
                                    st_next.ndum = `SFCP_BUF_RD_DUMMY;
                                    st_next.ph = hbusy ?
                                        ph_ignore : ph_dummy;
                                end
                                `SFCP_OP_BUF1_WR,
                                `SFCP_OP_BUF2_WR: begin
                                    st_next.ph = hbusy ?
                                        ph_ignore : ph_write;
                                end
                                default: begin
                                    st_next.ph = ph_armed;
                                end
                            endcase
                        end
                    end
                    ph_dummy: begin
                        st_next.bytec = st_reg.bytec + 3'h1;
                        if (st_reg.bytec == st_reg.ndum - 3'h1) begin
                            st_next.ph = ph_read;
                            do_load = 1'b1;
                        end
                    end
                    ph_read: begin
                        do_load = 1'b1;
                    end
                    ph_write: begin
                        // Bytes land at ascending buffer addresses.
                        wa_en = 1'b1;
                        wa_idx = bidx(hsel,
                                      st_reg.addr[`SFCP_BYTE_MSB:0]);
                        wa_data = in_byte;
                        st_next.addr[`SFCP_BYTE_MSB:0] =
                            step(st_reg.addr[`SFCP_BYTE_MSB:0]);
                    end
                    default: begin
                        st_next.ph = st_reg.ph;
                    end
                endcase
            end
        end else if (fall && st_reg.ph == ph_read) begin
            st_next.so = st_reg.sh_out[7];
            st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
            st_next.oe_n = 1'b0;
        end

        // Next read byte is staged on the rising edge ending a byte.
        if (do_load) begin
            if (st_reg.opcode == `SFCP_OP_STATUS) begin
                st_next.sh_out = stat;
            end else if (st_reg.opcode == `SFCP_OP_PAGE_RD) begin
                st_next.sh_out = core_rdata;
                st_next.walk = step(st_reg.walk);
            end else begin
                st_next.sh_out = rd_a;
                st_next.addr[`SFCP_BYTE_MSB:0] =
                    step(st_reg.addr[`SFCP_BYTE_MSB:0]);
            end
        end

        // Self-timed work owns the array pointer and walks the page
        // first; the rest of busy only holds the pin to the array time.
        if (st_reg.busy) begin
            {st_next.op_page, st_next.walk} = {st_reg.op_page, st_reg.walk};
            if (st_reg.walk != `SFCP_BUF_BYTES) begin
                st_next.walk = st_reg.walk + 10'h001;
                if (st_reg.op_cmp) begin
                    if (rd_b != core_rdata) begin
                        st_next.mismatch = 1'b1;
                    end
                end else begin
                    wb_en = 1'b1;
                    wb_idx = bidx(st_reg.busy_buf, st_reg.walk);
                    wb_data = core_rdata;
                end
            end
            st_next.timer = st_reg.timer - 16'h0001;
            if (st_reg.timer == 16'h0001) begin
                st_next.busy = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves mode 3, output released and the port idle.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.s1 <= 3'h6;
            st_reg.s2 <= 3'h6;
            st_reg.s3 <= 3'h6;
            st_reg.pins <= 3'h6;
            st_reg.oe_n <= 1'b1;
            st_reg.mode3 <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Two write ports; they never hit the same buffer at once.
    always_ff @(posedge clock) begin
        if (wa_en) begin
            buf_mem[wa_idx] <= wa_data;
        end
        if (wb_en) begin
            buf_mem[wb_idx] <= wb_data;
        end
    end

    // Outputs straight from state.
    assign so = st_reg.so;
    assign so_oe_n = st_reg.oe_n;
    assign rdy_busy_o = 1'b0;
    assign rdy_busy_oe_n = !st_reg.busy;
    assign core_req = {st_reg.op_page, st_reg.walk};
    assign spi_mode3 = st_reg.mode3;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_mode_latch: assert property ($fell(st_reg.pins.cs_n) |->
        st_reg.mode3 == st_reg.pins.sck)
        else $error("mode not latched at select fall");
    a_bit_sample: assert property ($rose(st_reg.pins.sck) &&
        !st_reg.pins.cs_n && !$fell(st_reg.pins.cs_n) |->
        st_reg.shin[0] == st_reg.pins.si)
        else $error("serial input not sampled on rise");
    a_byte_count: assert property ($rose(st_reg.pins.sck) &&
        !st_reg.pins.cs_n && !$fell(st_reg.pins.cs_n) |->
        st_reg.bitc == $past(st_reg.bitc) + 3'h1)
        else $error("bit counter did not step");
    a_status_byte: assert property ($past(st_reg.ph) == ph_cmd &&
        st_reg.ph == ph_read |-> st_reg.opcode == `SFCP_OP_STATUS &&
        st_reg.sh_out[5:3] == `SFCP_STAT_FIXED)
        else $error("status read framing wrong");
    a_busy_pin: assert property ($rose(st_reg.busy) |->
        st_reg.timer == 16'(XFR_CYCLES) && !rdy_busy_oe_n)
        else $error("busy start wrong");
    a_start_rise: assert property ($rose(st_reg.busy) |->
        $rose(st_reg.pins.cs_n))
        else $error("array work not started by select rise");
    a_page_field: assert property ($rose(st_reg.busy) |->
        st_reg.op_page ==
        $past(st_reg.addr[`SFCP_PAGE_MSB:`SFCP_PAGE_LSB]))
        else $error("page number taken from wrong bits");
    a_so_release: assert property (st_reg.pins.cs_n && !$rose(
        st_reg.pins.cs_n) |-> so_oe_n)
        else $error("output driven while deselected");
    a_so_falling: assert property ($changed(so) |->
        $fell(st_reg.pins.sck))
        else $error("output changed off a falling edge");
    a_write_decode: assert property ($past(st_reg.ph) == ph_addr &&
        st_reg.ph == ph_write |->
        st_reg.opcode == `SFCP_OP_BUF1_WR ||
        st_reg.opcode == `SFCP_OP_BUF2_WR)
        else $error("write phase from wrong opcode");

    c_status_read: cover property (st_reg.ph == ph_read &&
        st_reg.opcode == `SFCP_OP_STATUS && $fell(st_reg.pins.sck));
    c_buf_write: cover property (wa_en);
    c_transfer: cover property ($rose(st_reg.busy) && !st_reg.op_cmp);
    c_mismatch: cover property ($rose(st_reg.mismatch));
    c_mode0: cover property ($fell(st_reg.pins.cs_n) &&
        !st_reg.pins.sck);

endmodule
`default_nettype wire

// ### sim/serial_flash_command_port_bench.sv
// Self-checking bench of the serial flash command port.
`timescale 1ns/100ps
`default_nettype none
`include "sfcp_map.svh"

module serial_flash_command_port_bench import sfcp_pkg::*;;
    localparam int XFR = 600;
    logic clock = 1'b0;
    logic resetn;
    sfcp_pin_t spi_in;
    sfcp_core_req_t core_req;
    logic so, so_oe_n, rdy_busy_o, rdy_busy_oe_n, spi_mode3, rx_valid;
    logic [7:0] core_rdata, rx_data;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] mask_q[$];

    always #25 clock = ~clock;

    // Array content is a fixed mix of page and byte index.
    function automatic logic [7:0] arr(input logic [11:0] p,
                                       input logic [9:0] b);
        return p[7:0] ^ b[7:0] ^ {b[9:8], 2'b00, p[11:8]};
    endfunction
    assign core_rdata = arr(core_req.page, core_req.byte_idx);

    sfcp_port #(.XFR_CYCLES(XFR)) i_dut (.clock(clock), .resetn(resetn),
        .spi_in(spi_in), .so(so), .so_oe_n(so_oe_n),
        .rdy_busy_o(rdy_busy_o), .rdy_busy_oe_n(rdy_busy_oe_n),
        .core_req(core_req), .core_rdata(core_rdata),
        .spi_mode3(spi_mode3));

    sfcp_host_model i_host (.clock(clock), .pins(spi_in), .so(so),
        .rx_data(rx_data), .rx_valid(rx_valid));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Each captured read byte is matched with the oldest expectation.
    always @(posedge clock) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[ERR] %0t got %h exp %h", $time, rx_data, 8'h00);
            end else begin
                check(rx_data & mask_q[0], exp_q[0] & mask_q[0]);
                void'(exp_q.pop_front());
                void'(mask_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------------
    // Command helpers
    // ------------------------------------------------------------------
    task automatic cmd(input logic m, input logic [7:0] op,
                       input logic [23:0] addr, input int ndum);
        i_host.open_frame(m);
        check({7'h0, spi_mode3}, {7'h0, m});
        i_host.xfer(op, 1'b0);
        for (int k = 2; k >= 0; k--) begin
            i_host.xfer(addr[k*8 +: 8], 1'b0);
        end
        for (int k = 0; k < ndum; k++) begin
            i_host.xfer(8'h00, 1'b0);
        end
    endtask

    // The expectation goes in before the byte can come back.
    task automatic rd(input logic [7:0] exp, input logic [7:0] mask);
        exp_q.push_back(exp);
        mask_q.push_back(mask);
        i_host.xfer(8'h00, 1'b1);
        check({7'h0, so_oe_n}, 8'h00);
    endtask

    task automatic fin(input logic m, input logic chk);
        i_host.close_frame(m);
        if (chk) begin
            repeat (8) @(posedge clock);
            check({7'h0, so_oe_n}, 8'h01);
        end
    endtask

    task automatic status(input logic m, input logic rdy, input logic mis);
        i_host.open_frame(m);
        i_host.xfer(`SFCP_OP_STATUS, 1'b0);
        rd({rdy, mis, 6'b101000}, 8'hf8);
        fin(m, 1'b1);
    endtask

    // Busy must show within the deselect-to-busy limit and last the
    // self-timed span; the open-drain pin itself must stay low-valued.
    task automatic wait_busy();
        int n;
        n = 0;
        while (rdy_busy_oe_n !== 1'b0 && n < 12) begin
            @(posedge clock);
            n++;
        end
        if (n >= 12) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, rdy_busy_oe_n, 1'b0);
            finish_test();
        end
        n = 0;
        while (rdy_busy_oe_n === 1'b0 && n < XFR + 20) begin
            check({7'h0, rdy_busy_o}, 8'h00);
            @(posedge clock);
            n++;
        end
        check(8'(n >= XFR - 1 && n <= XFR + 1), 8'h01);
        if (n >= XFR + 20) begin
            finish_test();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] wr [2][3];
        logic [11:0] pg [2];
        resetn = 1'b0;
        void'($urandom(23));
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check({5'h0, so_oe_n, rdy_busy_oe_n, spi_mode3}, 8'h07);
        repeat (4) @(posedge clock);
        // Writes straddle the buffer end; buffer two gets junk high bits.
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 3; i++) begin
                wr[b][i] = 8'($urandom());
            end
            cmd(b[0], b[0] ? `SFCP_OP_BUF2_WR : `SFCP_OP_BUF1_WR,
                b[0] ? 24'hfffe0e : 24'h00020e, 0);
            for (int i = 0; i < 3; i++) begin
                i_host.xfer(wr[b][i], 1'b0);
            end
            fin(b[0], 1'b1);
        end
        for (int b = 0; b < 2; b++) begin
            cmd(~b[0], b[0] ? `SFCP_OP_BUF2_RD : `SFCP_OP_BUF1_RD,
                24'h00020e, 1);
            for (int i = 0; i < 3; i++) begin
                rd(wr[b][i], 8'hff);
            end
            fin(~b[0], 1'b1);
        end
        cmd(1'b0, `SFCP_OP_PAGE_RD, {2'b00, 12'ha5c, 10'h20f}, 4);
        rd(arr(12'ha5c, 10'h20f), 8'hff);
        rd(arr(12'ha5c, 10'h000), 8'hff);
        fin(1'b0, 1'b1);
        status(1'b1, 1'b1, 1'b0);
        // A transfer cut short after two address bytes must not start.
        i_host.open_frame(1'b1);
        i_host.xfer(`SFCP_OP_XFER1, 1'b0);
        i_host.xfer(8'h00, 1'b0);
        i_host.xfer(8'h00, 1'b0);
        fin(1'b1, 1'b0);
        repeat (12) @(posedge clock);
        check({7'h0, rdy_busy_oe_n}, 8'h01);
        // Pages differ in every byte, so a cross compare must mismatch.
        pg[0] = 12'($urandom());
        pg[1] = pg[0] ^ 12'h001;
        for (int t = 0; t < 2; t++) begin
            cmd(t[0], t[0] ? `SFCP_OP_XFER2 : `SFCP_OP_XFER1,
                {2'b00, pg[t], 10'h155}, 0);
            fin(t[0], 1'b0);
            fork
                wait_busy();
                begin
                    repeat (10) @(posedge clock);
                    if (t == 0) begin
                        cmd(1'b0, `SFCP_OP_BUF2_RD, 24'h00020e, 1);
                        rd(wr[1][0], 8'hff);
                        fin(1'b0, 1'b1);
                    end else begin
                        status(1'b0, 1'b0, 1'b0);
                        // A page read while busy is dropped unanswered.
                        cmd(1'b1, `SFCP_OP_PAGE_RD,
                            {2'b00, ~pg[1], 10'h000}, 0);
                        i_host.xfer(8'h00, 1'b0);
                        check({7'h0, so_oe_n}, 8'h01);
                        fin(1'b1, 1'b1);
                    end
                end
            join
            cmd(1'b1, t[0] ? `SFCP_OP_BUF2_RD : `SFCP_OP_BUF1_RD, 24'h0, 1);
            rd(arr(pg[t], 10'h000), 8'hff);
            rd(arr(pg[t], 10'h001), 8'hff);
            fin(1'b1, 1'b1);
        end
        for (int c = 0; c < 2; c++) begin
            cmd(1'b1, c[0] ? `SFCP_OP_CMP1 : `SFCP_OP_CMP2,
                {2'b00, pg[0], 10'h000}, 0);
            fin(1'b1, 1'b0);
            wait_busy();
            status(1'b1, 1'b1, ~c[0]);
        end
        finish_test();
    end
endmodule

`default_nettype wire

// ### sim/sfcp_host_model.sv
// Host master model for the serial link, modes 0 and 3, byte at a time.
`timescale 1ns/100ps
`default_nettype none

module sfcp_host_model import sfcp_pkg::*; (
    // Bench clock.
    input wire logic clock,
    // Link pins.
    output sfcp_pin_t pins,
    input wire logic so,
    // Bytes captured from the serial output.
    output logic [7:0] rx_data,
    output logic rx_valid
);
    logic active;

    // Deselected, mode 3 idle level, nothing captured yet.
    initial begin
        pins = '{cs_n: 1'b1, sck: 1'b1, si: 1'b0};
        active = 1'b0;
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end

    // Outside a frame nobody holds the input line, so it wanders.
    always @(posedge clock) begin
        if (!active) begin
            pins.si <= ~pins.si;
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // The idle clock level is set while deselected; it picks the mode.
    task automatic open_frame(input logic mode3);
        pins.sck <= mode3;
        wait_clk(6);
        active <= 1'b1;
        pins.cs_n <= 1'b0;
        wait_clk(6);
    endtask

    // One byte, MSB first: data set at the fall, held 200 ns either side
    // of the rise; the output is sampled just before the next fall.
    task automatic xfer(input logic [7:0] tx, input logic keep);
        for (int i = 7; i >= 0; i--) begin
            pins.sck <= 1'b0;
            pins.si <= tx[i];
            wait_clk(4);
            pins.sck <= 1'b1;
            wait_clk(4);
            rx_data <= {rx_data[6:0], so};
        end
        rx_valid <= keep;
        wait_clk(1);
        rx_valid <= 1'b0;
    endtask

    // Mode 0 returns the clock low before deselecting.
    task automatic close_frame(input logic mode3);
        if (!mode3) begin
            pins.sck <= 1'b0;
            wait_clk(4);
        end
        pins.cs_n <= 1'b1;
        active <= 1'b0;
    endtask
endmodule

`default_nettype wire
